// >>> dv/hsl_top_tb.sv
// hsl_top_tb: self-checking bench for the hdlc event latch and interrupt block
// assumes hsl_pkg and hsl_top compiled first; single ahb slave, one clock
`timescale 1ns/1ps

module hsl_top_tb;

  logic        clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [8:0]  ev, tx_level, rx_level;
  logic        in_pkt, bit_en, rx_bit, tx_below, rx_above;
  int          fails, n_compared;

  ////////////////////////////////////////////////////////////////////////////////
  hsl_top u_dut (
    .CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .TX_FETCH(ev[0]), .TX_LAST_BYTE_TAG(ev[1]), .TX_FIFO_WRITE(ev[2]),
    .TX_UNDERRUN(ev[3]), .TX_FIFO_LEVEL(tx_level), .RX_BIT_EN(bit_en),
    .RX_BIT(rx_bit), .RX_IN_PACKET(in_pkt), .RX_FLAG_SEEN(ev[4]),
    .RX_PKT_START(ev[5]), .RX_CLOSING_FLAG(ev[6]), .RX_FIFO_READ(ev[7]),
    .RX_OVERRUN(ev[8]), .RX_FIFO_LEVEL(rx_level),
    .TX_BELOW_THRESHOLD(tx_below), .RX_ABOVE_THRESHOLD(rx_above), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0, "bus wait");
  endtask : wait_rdy

  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    hsize  <= hsl_pkg::HSIZE_WORD;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    xfer(idx, 1'b1, {24'h0, d}, rd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    xfer(idx, 1'b0, 32'h0, rd);
    chk(rd, {24'h0, exp}, "register read");
    chk({31'h0, hresp}, 32'h0, "bus response");
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    #1;
    chk({31'h0, irq}, {31'h0, exp}, "irq level");
  endtask : irq_chk

  task automatic pulse(input logic [8:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 9'h000;
  endtask : pulse

  task automatic send_ones();
    @(posedge clk);
    bit_en <= 1'b1;
    rx_bit <= 1'b0;
    @(posedge clk);
    rx_bit <= 1'b1;
    repeat (6) @(posedge clk);
    @(posedge clk);
    bit_en <= 1'b0;
  endtask : send_ones

  task automatic do_event(input int b);
    case (b)
      0: pulse(9'h003);
      1: begin pulse(9'h004); pulse(9'h008); end
      2: begin @(posedge clk); tx_level <= 9'd10; repeat (4) @(posedge clk); end
      3: begin @(posedge clk); rx_level <= 9'd20; repeat (4) @(posedge clk); end
      4: begin pulse(9'h010); send_ones(); end
      5: pulse(9'h020);
      6: pulse(9'h040);
      default: pulse(9'h100);
    endcase
  endtask : do_event

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    logic [7:0] exp;
    fails = 0; n_compared = 0; nrst = 1'b0; hsel = 1'b0; htrans = 2'b00;
    haddr = 32'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ev = 9'h000;
    tx_level = 9'd100; rx_level = 9'd0; in_pkt = 1'b0; bit_en = 1'b0; rx_bit = 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(hsl_pkg::IDX_IRQ_EN, 8'h00);
    rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    irq_chk(1'b0);
    $display("test reset values done");
    in_pkt <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      do_event(b);
      exp = (b == 1) ? 8'h03 : (8'h01 << b);
      rd_chk(hsl_pkg::IDX_LATCH, exp);
      wr(hsl_pkg::IDX_LATCH, 8'h00);
      rd_chk(hsl_pkg::IDX_LATCH, exp);
      wr(hsl_pkg::IDX_LATCH, 8'hff);
      rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    end
    $display("test event latching done");
    rd_chk(hsl_pkg::IDX_RT_STATUS, 8'h0c);
    chk({30'h0, rx_above, tx_below}, 32'h3, "threshold pins");
    wr(hsl_pkg::IDX_LEVEL_SEL, 8'h11);
    rd_chk(hsl_pkg::IDX_LEVEL_SEL, 8'h11);
    rd_chk(hsl_pkg::IDX_RT_STATUS, 8'h04);
    pulse(9'h008);
    pulse(9'h100);
    rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    send_ones();
    rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    @(posedge clk);
    in_pkt <= 1'b0;
    pulse(9'h010);
    send_ones();
    rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    pulse(9'h080);
    pulse(9'h100);
    rd_chk(hsl_pkg::IDX_LATCH, 8'h80);
    @(posedge clk);
    tx_level <= 9'd100;
    rx_level <= 9'd0;
    repeat (4) @(posedge clk);
    rd_chk(hsl_pkg::IDX_RT_STATUS, 8'h00);
    chk({30'h0, rx_above, tx_below}, 32'h0, "threshold pins");
    wr(hsl_pkg::IDX_LATCH, 8'hff);
    $display("test rearm done");
    wr(hsl_pkg::IDX_IRQ_EN, 8'hff);
    rd_chk(hsl_pkg::IDX_IRQ_EN, 8'hff);
    do_event(5);
    irq_chk(1'b0);
    wr(hsl_pkg::IDX_MASTER_EN, 8'h01);
    irq_chk(1'b1);
    wr(hsl_pkg::IDX_IRQ_EN, 8'hdf);
    irq_chk(1'b0);
    wr(hsl_pkg::IDX_IRQ_EN, 8'hff);
    irq_chk(1'b1);
    wr(hsl_pkg::IDX_MASTER_EN, 8'h00);
    irq_chk(1'b0);
    wr(hsl_pkg::IDX_MASTER_EN, 8'h01);
    wr(hsl_pkg::IDX_LATCH_CLR, 8'h20);
    irq_chk(1'b0);
    rd_chk(hsl_pkg::IDX_LATCH_CLR, 8'h00);
    rd_chk(8'h60, 8'h00);
    $display("test interrupt done");
    do_event(5);
    irq_chk(1'b1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(hsl_pkg::IDX_LATCH, 8'h00);
    rd_chk(hsl_pkg::IDX_IRQ_EN, 8'h00);
    irq_chk(1'b0);
    $display("test second reset done");
    print_verdict();
  end

endmodule : hsl_top_tb

// >>> logic/hsl_pkg.sv
// hsl_pkg: constants and types for the hdlc event latch and interrupt block
// assumes an ahb-lite master with 32-bit word accesses and one clock domain
//
// Notes on behaviour
// - tx packet-end flag sets on a tagged last-byte fetch or on an underrun
// - a latched flag clears only when software writes 1; writing 0 keeps it
// - interrupt only while flag set, its enable set and group enable set
// - contribution drops at once when flag, its enable or group enable clears
// - underrun flag sets per underrun; rearms only after the fifo is written again
// - tx low-level flag sets on each rising edge of the live below-threshold status
// - rx high-level flag sets on each rising edge of the live above-threshold status
// - abort flag sets on seven or more consecutive ones inside a packet
// - an abort pattern while idle, outside a packet, sets nothing
// - after an abort, a valid flag must arrive before another abort counts
// - packet-start flag sets on each detected start of an incoming packet
// - packet-end flag sets on every closing flag in a packet, good or bad
// - overrun flag sets per overrun; rearms only after the fifo is read
// - latch layout: overrun bit 7 down to tx packet-end bit 0
// - one enable per flag at matching bits, 1 enables, all reset to 0
// - live tx status high while tx fifo holds fewer bytes than its threshold
// - live rx status high while rx fifo holds more bytes than its threshold

package hsl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_LEVEL_SEL  = 8'h51;
  localparam logic [7:0] IDX_RT_STATUS  = 8'h54;
  localparam logic [7:0] IDX_LATCH      = 8'h55;
  localparam logic [7:0] IDX_IRQ_EN     = 8'h56;
  localparam logic [7:0] IDX_LATCH_CLR  = 8'h58;
  localparam logic [7:0] IDX_MASTER_EN  = 8'h5b;

  ////////////////////////////////////////////////////////////////////////////////
  // latch and enable bit positions
  localparam int BIT_TX_PKT_END   = 0;
  localparam int BIT_TX_UNDERRUN  = 1;
  localparam int BIT_TX_LOW_LEVEL = 2;
  localparam int BIT_RX_HIGH_LVL  = 3;
  localparam int BIT_RX_ABORT     = 4;
  localparam int BIT_RX_PKT_START = 5;
  localparam int BIT_RX_PKT_END   = 6;
  localparam int BIT_RX_OVERRUN   = 7;
  localparam int NUM_FLAGS        = 8;

  // live status bits and level select fields
  localparam int RT_TX_BELOW      = 2;
  localparam int RT_RX_ABOVE      = 3;
  localparam int SEL_TX_LSB       = 0;
  localparam int SEL_RX_LSB       = 4;
  localparam int MASTER_HDLC_BIT  = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and counts
  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_LEVEL_SEL = 8'h00;
  localparam logic [7:0] RST_MASTER_EN = 8'h00;
  localparam logic [8:0] LEVEL_BASE    = 9'h010;
  localparam logic [8:0] LEVEL_STEP    = 9'h020;
  localparam logic [2:0] ABORT_ONES    = 3'h7;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // captured address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] idx;
  } hsl_req_t;

endpackage : hsl_pkg

// >>> logic/hsl_top.sv
// hsl_top: hdlc event latch, per-flag enables and interrupt output
// assumes ahb-lite with one slave, event inputs synchronous to CLK
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps

module hsl_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        NRST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // transmit controller
  input  wire logic        TX_FETCH,
  input  wire logic        TX_LAST_BYTE_TAG,
  input  wire logic        TX_FIFO_WRITE,
  input  wire logic        TX_UNDERRUN,
  input  wire logic [8:0]  TX_FIFO_LEVEL,
  // receive controller
  input  wire logic        RX_BIT_EN,
  input  wire logic        RX_BIT,
  input  wire logic        RX_IN_PACKET,
  input  wire logic        RX_FLAG_SEEN,
  input  wire logic        RX_PKT_START,
  input  wire logic        RX_CLOSING_FLAG,
  input  wire logic        RX_FIFO_READ,
  input  wire logic        RX_OVERRUN,
  input  wire logic [8:0]  RX_FIFO_LEVEL,
  // status and interrupt
  output logic             TX_BELOW_THRESHOLD,
  output logic             RX_ABOVE_THRESHOLD,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic [7:0] fn_idx(input logic [31:0] addr);
    fn_idx = addr[9:2];
  endfunction : fn_idx

  function automatic logic [8:0] fn_level(input logic [2:0] sel);
    fn_level = hsl_pkg::LEVEL_BASE + 9'(hsl_pkg::LEVEL_STEP * sel);
  endfunction : fn_level

  ////////////////////////////////////////////////////////////////////////////////
  // state
  hsl_pkg::hsl_req_t req_reg;
  hsl_pkg::hsl_req_t req_next;
  logic        rd_wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  latch_reg;
  logic [7:0]  latch_next;
  logic [7:0]  irq_en_reg;
  logic [7:0]  level_sel_reg;
  logic [7:0]  master_en_reg;
  logic        tx_below_reg;
  logic        tx_below_prev_reg;
  logic        rx_above_reg;
  logic        rx_above_prev_reg;
  logic        tx_udr_armed_reg;
  logic        rx_ovr_armed_reg;
  logic        abort_armed_reg;
  logic [2:0]  ones_reg;
  logic [2:0]  ones_next;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire        addr_ok    = HSEL & HTRANS[1] & HREADY & (HSIZE == hsl_pkg::HSIZE_WORD)
                           & (HADDR[1:0] == 2'h0);
  wire        wr_phase   = req_reg.valid & req_reg.write & HREADY;
  wire        wr_irq_en  = wr_phase & (req_reg.idx == hsl_pkg::IDX_IRQ_EN);
  wire        wr_sel     = wr_phase & (req_reg.idx == hsl_pkg::IDX_LEVEL_SEL);
  wire        wr_master  = wr_phase & (req_reg.idx == hsl_pkg::IDX_MASTER_EN);
  wire        wr_clear   = wr_phase & ((req_reg.idx == hsl_pkg::IDX_LATCH)
                           | (req_reg.idx == hsl_pkg::IDX_LATCH_CLR));
  wire [7:0]  clr_mask   = wr_clear ? HWDATA[7:0] : 8'h00;
  wire        group_en   = master_en_reg[hsl_pkg::MASTER_HDLC_BIT];
  wire [7:0]  rt_status  = {4'h0, rx_above_reg, tx_below_reg, 2'h0};

  assign req_next = '{valid: addr_ok, write: HWRITE, idx: fn_idx(HADDR)};

  wire [7:0]  rd_sel =
    (req_reg.idx == hsl_pkg::IDX_LEVEL_SEL) ? level_sel_reg :
    (req_reg.idx == hsl_pkg::IDX_RT_STATUS) ? rt_status :
    (req_reg.idx == hsl_pkg::IDX_LATCH)     ? latch_reg :
    (req_reg.idx == hsl_pkg::IDX_IRQ_EN)    ? irq_en_reg :
    (req_reg.idx == hsl_pkg::IDX_MASTER_EN) ? master_en_reg : 8'h00;

  assign HREADYOUT = ~rd_wait_reg;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // bus registers
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      req_reg     <= '0;
      rd_wait_reg <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      if (HREADY) begin
        req_reg <= req_next;
      end
      rd_wait_reg <= addr_ok & ~HWRITE;
      if (rd_wait_reg) begin
        rdata_reg <= {24'h00_0000, rd_sel};
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      irq_en_reg    <= hsl_pkg::RST_IRQ_EN;
      level_sel_reg <= hsl_pkg::RST_LEVEL_SEL;
      master_en_reg <= hsl_pkg::RST_MASTER_EN;
    end else begin
      if (wr_irq_en) begin
        irq_en_reg <= HWDATA[7:0];
      end
      if (wr_sel) begin
        level_sel_reg <= HWDATA[7:0];
      end
      if (wr_master) begin
        master_en_reg <= HWDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // live fifo level status
  wire [8:0] tx_level = fn_level(level_sel_reg[hsl_pkg::SEL_TX_LSB +: 3]);
  wire [8:0] rx_level = fn_level(level_sel_reg[hsl_pkg::SEL_RX_LSB +: 3]);
  wire       tx_below = TX_FIFO_LEVEL < tx_level;
  wire       rx_above = RX_FIFO_LEVEL > rx_level;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_below_reg      <= 1'b0;
      tx_below_prev_reg <= 1'b0;
      rx_above_reg      <= 1'b0;
      rx_above_prev_reg <= 1'b0;
    end else begin
      tx_below_reg      <= tx_below;
      tx_below_prev_reg <= tx_below_reg;
      rx_above_reg      <= rx_above;
      rx_above_prev_reg <= rx_above_reg;
    end
  end

  assign TX_BELOW_THRESHOLD = tx_below_reg;
  assign RX_ABOVE_THRESHOLD = rx_above_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // event qualification
  wire udr_evt   = TX_UNDERRUN & tx_udr_armed_reg;
  wire ovr_evt   = RX_OVERRUN & rx_ovr_armed_reg;
  wire abort_evt = RX_BIT_EN & RX_BIT & (ones_reg == hsl_pkg::ABORT_ONES - 3'h1)
                   & RX_IN_PACKET & abort_armed_reg;

  assign ones_next = !RX_BIT_EN ? ones_reg :
                     !RX_BIT ? 3'h0 :
                     (ones_reg == hsl_pkg::ABORT_ONES) ? ones_reg : ones_reg + 3'h1;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      tx_udr_armed_reg <= 1'b0;
      rx_ovr_armed_reg <= 1'b1;
      abort_armed_reg  <= 1'b0;
      ones_reg         <= 3'h0;
    end else begin
      tx_udr_armed_reg <= TX_FIFO_WRITE | (tx_udr_armed_reg & ~udr_evt);
      rx_ovr_armed_reg <= RX_FIFO_READ | (rx_ovr_armed_reg & ~ovr_evt);
      abort_armed_reg  <= RX_FLAG_SEEN | (abort_armed_reg & ~abort_evt);
      ones_reg         <= ones_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // latched flags, set wins over clear
  logic [7:0] set_vec;
  assign set_vec[hsl_pkg::BIT_TX_PKT_END]   = (TX_FETCH & TX_LAST_BYTE_TAG) | udr_evt;
  assign set_vec[hsl_pkg::BIT_TX_UNDERRUN]  = udr_evt;
  assign set_vec[hsl_pkg::BIT_TX_LOW_LEVEL] = tx_below_reg & ~tx_below_prev_reg;
  assign set_vec[hsl_pkg::BIT_RX_HIGH_LVL]  = rx_above_reg & ~rx_above_prev_reg;
  assign set_vec[hsl_pkg::BIT_RX_ABORT]     = abort_evt;
  assign set_vec[hsl_pkg::BIT_RX_PKT_START] = RX_PKT_START;
  assign set_vec[hsl_pkg::BIT_RX_PKT_END]   = RX_CLOSING_FLAG & RX_IN_PACKET;
  assign set_vec[hsl_pkg::BIT_RX_OVERRUN]   = ovr_evt;

  assign latch_next = (latch_reg & ~clr_mask) | set_vec;

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      latch_reg <= hsl_pkg::RST_LATCH;
    end else begin
      latch_reg <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt combine
  logic [7:0] irq_bit;
  genvar gi;
  generate
    for (gi = 0; gi < hsl_pkg::NUM_FLAGS; gi++) begin : g_irq
      assign irq_bit[gi] = latch_reg[gi] & irq_en_reg[gi] & group_en;
    end
  endgenerate

  assign IRQ = |irq_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  AST_SET_WINS: assert property (
    set_vec[hsl_pkg::BIT_RX_PKT_START] |=> latch_reg[hsl_pkg::BIT_RX_PKT_START])
    else $error("packet-start set lost");

  AST_W1C_CLEARS: assert property (
    wr_clear && HWDATA[hsl_pkg::BIT_RX_ABORT] && !set_vec[hsl_pkg::BIT_RX_ABORT]
    |=> !latch_reg[hsl_pkg::BIT_RX_ABORT])
    else $error("write one did not clear abort flag");

  AST_HOLD_NO_CLEAR: assert property (
    latch_reg[hsl_pkg::BIT_TX_UNDERRUN] && !(wr_clear && HWDATA[hsl_pkg::BIT_TX_UNDERRUN])
    |=> latch_reg[hsl_pkg::BIT_TX_UNDERRUN])
    else $error("underrun flag dropped without write one");

  AST_IRQ_CAUSE: assert property (
    IRQ |-> group_en && ((latch_reg & irq_en_reg) != 8'h00))
    else $error("interrupt without enabled flag");

  AST_IRQ_GROUP_OFF: assert property (
    wr_master && !HWDATA[hsl_pkg::MASTER_HDLC_BIT] |=> !IRQ)
    else $error("interrupt stayed after group disable");

  AST_UDR_REARM: assert property (
    udr_evt && !TX_FIFO_WRITE |=> !udr_evt)
    else $error("underrun counted twice without a write");

  AST_TX_EDGE: assert property (
    $rose(tx_below_reg) |=> latch_reg[hsl_pkg::BIT_TX_LOW_LEVEL])
    else $error("low-level edge not latched");

  AST_RX_EDGE: assert property (
    $rose(rx_above_reg) |=> latch_reg[hsl_pkg::BIT_RX_HIGH_LVL])
    else $error("high-level edge not latched");

  AST_ABORT_IDLE: assert property (
    !RX_IN_PACKET |-> !abort_evt)
    else $error("abort taken outside a packet");

  AST_ABORT_ONCE: assert property (
    abort_evt && !RX_FLAG_SEEN |=> !abort_evt)
    else $error("second abort without a flag");

  AST_PKT_END: assert property (
    RX_CLOSING_FLAG && RX_IN_PACKET |=> latch_reg[hsl_pkg::BIT_RX_PKT_END])
    else $error("closing flag not latched");

  AST_EN_RESET: assert property (
    $rose(NRST) |-> irq_en_reg == 8'h00)
    else $error("enables not reset");

  AST_RST_LATCH: assert property (
    $rose(NRST) |-> latch_reg == 8'h00)
    else $error("flags not cleared by reset");

  AST_TX_PKT_END: assert property (
    TX_FETCH && TX_LAST_BYTE_TAG |=> latch_reg[hsl_pkg::BIT_TX_PKT_END])
    else $error("tagged last byte not latched");

  AST_UDR_BOTH: assert property (
    udr_evt |=> latch_reg[hsl_pkg::BIT_TX_PKT_END] && latch_reg[hsl_pkg::BIT_TX_UNDERRUN])
    else $error("underrun not latched in both flags");

  AST_IRQ_ON: assert property (
    group_en && ((latch_reg & irq_en_reg) != 8'h00) |-> IRQ)
    else $error("enabled flag without interrupt");

  AST_ABORT_SET: assert property (
    abort_evt |=> latch_reg[hsl_pkg::BIT_RX_ABORT])
    else $error("abort not latched");

  AST_OVR_REARM: assert property (
    ovr_evt && !RX_FIFO_READ |=> !ovr_evt)
    else $error("overrun counted twice without a read");

  AST_OVR_SET: assert property (
    ovr_evt |=> latch_reg[hsl_pkg::BIT_RX_OVERRUN])
    else $error("overrun not latched");

  AST_RT_TX: assert property (
    TX_FIFO_LEVEL < tx_level |=> TX_BELOW_THRESHOLD)
    else $error("tx below-threshold status missing");

  AST_RT_RX: assert property (
    RX_FIFO_LEVEL > rx_level |=> RX_ABOVE_THRESHOLD)
    else $error("rx above-threshold status missing");

endmodule : hsl_top
